// ### hdl/irqpe_top.sv
// Pending request latches, group 0 priority enables and request forwarding
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - A presented source request sets its pending bit to one.
// - With global enable set, forward the best enabled pending request to the core.
// - With global enable clear, forward nothing; pending registers stay readable.
// - Port A bit 7 records pin 7 or low-voltage detector; bits 5..0 record pins 0..5.
// - Port A bit 6 records pin 6 or the comparator.
// - Port C bits 3..0 record requests from port C pins 0..3.
// - Enable pair 00 disabled, 01 level 1, 10 level 2, 11 level 3.
// - Group 0 has separate high and low eight-bit enables, bit x pairs pending bit x.
// - Timer1 bit 6, timer0 bit 5, rx bit 4, tx bit 3, converter bit 0.
// - Reserved bits 7, 2, 1 written zero; read-only in the low enable register.
// - Level 3 beats level 2, level 2 beats level 1, when choosing a request.
// - Core acknowledge clears the source's pending bit until it requests again.
// - Software write of one raises a request, write of zero clears it.
module irqpe_top
    import irqpe_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Request pulses from sources
    input wire logic [7:0] port_a_pin_pulse,
    input wire logic low_voltage_detector,
    input wire logic comparator_pulse,
    input wire logic [3:0] port_c_pin_pulse,
    // Group 0 pending bits held elsewhere, and enables of the port groups
    input wire logic [7:0] group0_pending_requests,
    input wire logic [7:0] port_a_level_high,
    input wire logic [7:0] port_a_level_low,
    input wire logic [3:0] port_c_level_high,
    input wire logic [3:0] port_c_level_low,
    // Core side
    input wire logic global_enable,
    input wire logic core_ack,
    input wire logic [4:0] core_ack_source,
    output logic core_request,
    output logic [4:0] core_source,
    output logic [1:0] core_level,
    output logic [7:0] group0_ack_clear,
    // Interrupt output
    output logic irq_out
);

    // Decode of an enable pair into a level
    function automatic logic [1:0] level_of(input logic hi, input logic lo);
        level_of = {hi, lo};
    endfunction

    // Write strobe of one mapped register
    function automatic logic write_hit(input logic en, input logic [11:0] idx,
        input logic [11:0] target);
        write_hit = en && (idx == target);
    endfunction

    // Bus state
    irqpe_bus_state_t bus_state;
    irqpe_bus_state_t next_bus_state;
    logic [31:0] next_wb_dat_o;

    // Register state
    // Port C keeps only its four real bits
    logic [7:0] group0_priority_high;
    logic [7:0] group0_priority_low;
    logic [7:0] port_a_pending_requests;
    logic [3:0] port_c_pending_requests;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] next_group0_priority_high;
    logic [7:0] next_group0_priority_low;
    logic [7:0] next_port_a_pending_requests;
    logic [3:0] next_port_c_pending_requests;
    logic [2:0] next_irq_status;
    logic [2:0] next_irq_mask;

    // Presentation state
    logic next_core_request;
    logic [4:0] next_core_source;
    logic [1:0] next_core_level;
    logic [7:0] next_group0_ack_clear;

    // Shared decode
    logic bus_req;
    logic wr_en;
    logic [11:0] reg_idx;
    logic [7:0] pa_set;
    logic [3:0] pc_set;
    logic [NUM_SOURCES-1:0] ack_vec;
    logic [NUM_SOURCES-1:0] all_pend;
    logic [NUM_SOURCES-1:0] all_hi;
    logic [NUM_SOURCES-1:0] all_lo;

    // Request is taken on the first cycle only; ack rises the cycle after, for one cycle
    // The ack cycle is never taken as a second request
    assign bus_req = wb_cyc_i && wb_stb_i && (bus_state == BUS_IDLE);
    assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
    assign reg_idx = wb_adr_i[13:2];

    // Shared slots are ORed so either source lands in the same bit
    always_comb begin
        pa_set = port_a_pin_pulse;
        pa_set[PA_LOWVOLT_BIT] = port_a_pin_pulse[PA_LOWVOLT_BIT] | low_voltage_detector;
        pa_set[PA_COMPARATOR_BIT] = port_a_pin_pulse[PA_COMPARATOR_BIT] | comparator_pulse;
        pc_set = port_c_pin_pulse;
    end

    // One-hot of the acknowledged source
    // Out-of-range numbers are dropped rather than wrapped onto a real source
    always_comb begin
        ack_vec = '0;
        if (core_ack && (core_ack_source < 5'(NUM_SOURCES))) begin
            ack_vec[core_ack_source] = 1'b1;
        end
    end

    // Flattened view of every source
    assign all_pend = {port_c_pending_requests, port_a_pending_requests, group0_pending_requests};
    assign all_hi = {port_c_level_high, port_a_level_high, group0_priority_high};
    assign all_lo = {port_c_level_low, port_a_level_low, group0_priority_low};

    // Bus state and read data
    // Only byte lane 0 carries data; reads zero-fill the rest
    always_comb begin
        next_bus_state = BUS_IDLE;
        next_wb_dat_o = wb_dat_o;
        unique case (bus_state)
            BUS_IDLE: begin
                if (bus_req) begin
                    next_bus_state = BUS_ACK;
                    next_wb_dat_o = '0;
                    if (!wb_we_i) begin
                        // Unmapped addresses read as zero
                        unique case (reg_idx)
                            IDX_G0_PRIO_HIGH: next_wb_dat_o[7:0] = group0_priority_high;
                            IDX_G0_PRIO_LOW: next_wb_dat_o[7:0] = group0_priority_low;
                            IDX_PORT_A_PEND: next_wb_dat_o[7:0] = port_a_pending_requests;
                            IDX_PORT_C_PEND: next_wb_dat_o[3:0] = port_c_pending_requests;
                            IDX_IRQ_STATUS: next_wb_dat_o[2:0] = irq_status;
                            IDX_IRQ_MASK: next_wb_dat_o[2:0] = irq_mask;
                            default: next_wb_dat_o = '0;
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    // Bus flops
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bus_state <= BUS_IDLE;
            wb_dat_o <= '0;
        end else begin
            bus_state <= next_bus_state;
            wb_dat_o <= next_wb_dat_o;
        end
    end

    // Acknowledge is given in the cycle after the request is taken
    assign wb_ack_o = (bus_state == BUS_ACK);

    // Enable registers; reserved low bits never take a write
    always_comb begin
        next_group0_priority_high = group0_priority_high;
        next_group0_priority_low = group0_priority_low;
        next_irq_mask = irq_mask;
        // High register keeps reserved bits as written; software keeps them zero
        if (write_hit(wr_en, reg_idx, IDX_G0_PRIO_HIGH)) begin
            next_group0_priority_high = wb_dat_i[7:0];
        end
        if (write_hit(wr_en, reg_idx, IDX_G0_PRIO_LOW)) begin
            next_group0_priority_low = wb_dat_i[7:0] & G0_LOW_WRITABLE;
        end
        if (write_hit(wr_en, reg_idx, IDX_IRQ_MASK)) begin
            next_irq_mask = wb_dat_i[2:0];
        end
    end

    // Enable and mask flops
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            group0_priority_high <= RST_G0_PRIO_HIGH;
            group0_priority_low <= RST_G0_PRIO_LOW;
            irq_mask <= RST_IRQ_MASK;
        end else begin
            group0_priority_high <= next_group0_priority_high;
            group0_priority_low <= next_group0_priority_low;
            irq_mask <= next_irq_mask;
        end
    end

    // Pending bits: write replaces, ack clears, a fresh request always wins
    always_comb begin
        next_port_a_pending_requests = port_a_pending_requests & ~ack_vec[15:8];
        next_port_c_pending_requests = port_c_pending_requests & ~ack_vec[19:16];
        if (write_hit(wr_en, reg_idx, IDX_PORT_A_PEND)) begin
            next_port_a_pending_requests = wb_dat_i[7:0];
        end
        if (write_hit(wr_en, reg_idx, IDX_PORT_C_PEND)) begin
            // Upper bits are expected zero and are not stored
            next_port_c_pending_requests = wb_dat_i[3:0];
        end
        // Applied last, so a request never gets lost to a racing clear
        next_port_a_pending_requests = next_port_a_pending_requests | pa_set;
        next_port_c_pending_requests = next_port_c_pending_requests | pc_set;
    end

    // Pending flops
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            port_a_pending_requests <= RST_PORT_A_PEND;
            port_c_pending_requests <= RST_PORT_C_PEND;
        end else begin
            port_a_pending_requests <= next_port_a_pending_requests;
            port_c_pending_requests <= next_port_c_pending_requests;
        end
    end

    // Arbitration: highest level first, lowest source number within a level
    // Limitation: fixed order in a level, a busy low number can starve others
    always_comb begin
        logic [1:0] lvl;
        lvl = LEVEL_DISABLED;
        next_core_source = '0;
        next_core_level = LEVEL_DISABLED;
        // Strict compare keeps the lowest source number within a level
        for (int i = 0; i < NUM_SOURCES; i++) begin
            lvl = level_of(all_hi[i], all_lo[i]);
            // Disabled pairs never compete, the pending bit is left alone
            if (all_pend[i] && lvl != LEVEL_DISABLED && lvl > next_core_level) begin
                next_core_level = lvl;
                next_core_source = 5'(i);
            end
        end
        // Nothing goes out while interrupts are globally off
        next_core_request = global_enable && (next_core_level != LEVEL_DISABLED);
        if (!next_core_request) begin
            next_core_level = LEVEL_DISABLED;
            next_core_source = '0;
        end
        // Group 0 bits live outside, so their clear leaves as a pulse
        next_group0_ack_clear = ack_vec[7:0];
    end

    // Registered so the core only ever sees settled values
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            core_request <= 1'b0;
            core_source <= '0;
            core_level <= LEVEL_DISABLED;
            group0_ack_clear <= '0;
        end else begin
            core_request <= next_core_request;
            core_source <= next_core_source;
            core_level <= next_core_level;
            group0_ack_clear <= next_group0_ack_clear;
        end
    end

    // Sticky status, write one to clear, a new event wins over the clear
    // Status only records events; requests travel on the pending path
    always_comb begin
        next_irq_status = irq_status;
        if (write_hit(wr_en, reg_idx, IDX_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~wb_dat_i[2:0];
        end
        next_irq_status[ST_PORT_A_EVENT] = next_irq_status[ST_PORT_A_EVENT] | (|pa_set);
        next_irq_status[ST_PORT_C_EVENT] = next_irq_status[ST_PORT_C_EVENT] | (|pc_set);
        next_irq_status[ST_CORE_ACK_EVENT] = next_irq_status[ST_CORE_ACK_EVENT] | (|ack_vec);
    end

    // Status flops
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_status <= RST_IRQ_STATUS;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Level output while any unmasked status bit stands
    // Built from flops only, so bus decode cannot glitch it
    assign irq_out = |(irq_status & irq_mask);

endmodule // irqpe_top

`default_nettype wire

// ### shared/irqpe_pkg.sv
// Package of register map, field layout and encodings for the pending and priority block
package irqpe_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_G0_PRIO_HIGH = 12'h0fc1;
    localparam logic [11:0] IDX_G0_PRIO_LOW = 12'h0fc2;
    localparam logic [11:0] IDX_PORT_A_PEND = 12'h0fc3;
    localparam logic [11:0] IDX_PORT_C_PEND = 12'h0fc6;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h0fd0;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h0fd1;

    // Reset values
    localparam logic [7:0] RST_G0_PRIO_HIGH = 8'h00;
    localparam logic [7:0] RST_G0_PRIO_LOW = 8'h00;
    localparam logic [7:0] RST_PORT_A_PEND = 8'h00;
    localparam logic [3:0] RST_PORT_C_PEND = 4'h0;
    localparam logic [2:0] RST_IRQ_STATUS = 3'h0;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

    // Writable bits of the low enable register: timer1, timer0, rx, tx, converter
    localparam logic [7:0] G0_LOW_WRITABLE = 8'h79;
    localparam int G0_TIMER1_BIT = 6;
    localparam int G0_TIMER0_BIT = 5;
    localparam int G0_SERIAL_RX_BIT = 4;
    localparam int G0_SERIAL_TX_BIT = 3;
    localparam int G0_CONVERTER_BIT = 0;

    // Port A shared slots
    localparam int PA_LOWVOLT_BIT = 7;
    localparam int PA_COMPARATOR_BIT = 6;

    // Source numbering towards the core: group 0, then port A, then port C
    localparam int NUM_SOURCES = 20;
    localparam logic [4:0] SRC_BASE_PORT_A = 5'd8;
    localparam logic [4:0] SRC_BASE_PORT_C = 5'd16;

    // Priority levels
    localparam logic [1:0] LEVEL_DISABLED = 2'b00;
    localparam logic [1:0] LEVEL_1 = 2'b01;
    localparam logic [1:0] LEVEL_2 = 2'b10;
    localparam logic [1:0] LEVEL_3 = 2'b11;

    // Status and mask bit positions
    localparam int ST_PORT_A_EVENT = 0;
    localparam int ST_PORT_C_EVENT = 1;
    localparam int ST_CORE_ACK_EVENT = 2;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } irqpe_bus_state_t;

endpackage

// ### tb/irqpe_assertions.sv
// Port checker for bus handshake and request forwarding
`timescale 1ns/1ns
`default_nettype none
module irqpe_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Enables and core side
    input wire logic [7:0] port_a_level_high,
    input wire logic [7:0] port_a_level_low,
    input wire logic global_enable,
    input wire logic core_ack,
    input wire logic [4:0] core_ack_source,
    input wire logic core_request,
    input wire logic [4:0] core_source,
    input wire logic [1:0] core_level,
    input wire logic [7:0] group0_ack_clear
);
    // Single domain, so one default clock and disable
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
    property p_no_fwd; !global_enable |=> !core_request && core_level == 2'h0; endproperty
    property p_level_nz; core_request |-> core_level != 2'h0; endproperty
    // Level follows the enable pair of port A bit 2 while source 10 is presented
    property p_src10;
        core_request && core_source == 5'h0a && $stable(port_a_level_high)
            && $stable(port_a_level_low) |-> core_level == {port_a_level_high[2],
            port_a_level_low[2]};
    endproperty
    property p_g0_clear; core_ack && core_ack_source < 5'h08
        |=> group0_ack_clear == 8'h01 << $past(core_ack_source); endproperty
    property p_g0_quiet; !core_ack |=> group0_ack_clear == 8'h00; endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("bus request not acknowledged");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    a_dat_upper: assert property (p_dat_upper)
        else $error("upper read data not zero");
    a_no_fwd: assert property (p_no_fwd)
        else $error("request forwarded while disabled");
    a_level_nz: assert property (p_level_nz)
        else $error("disabled source forwarded");
    a_src10: assert property (p_src10)
        else $error("level does not match enable pair");
    a_g0_clear: assert property (p_g0_clear)
        else $error("wrong group clear pulse");
    a_g0_quiet: assert property (p_g0_quiet)
        else $error("group clear without ack");
    // Main scenarios reached
    c_ack: cover property (core_ack);
    c_bus: cover property (wb_ack_o);
    c_top: cover property (core_request && core_level == 2'h3);
endmodule // irqpe_assertions
`default_nettype wire

// ### tb/irqpe_core_model.sv
// Behavioural core that acknowledges presented requests after a set delay
`timescale 1ns/1ns
`default_nettype none
module irqpe_core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Request and chosen delay
    input wire logic core_request,
    input wire logic [4:0] core_source,
    input wire logic [3:0] lat,
    // Acknowledge
    output logic core_ack,
    output logic [4:0] core_ack_source
);
    logic [3:0] wait_cnt;
    logic [1:0] hold;
    // Hold off after an ack, the old source may still show a cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            core_ack <= 1'h0;
            core_ack_source <= 5'h00;
            wait_cnt <= 4'h0;
            hold <= 2'h0;
        end else begin
            core_ack <= 1'h0;
            if (core_ack) hold <= 2'h3;
            else if (hold != 2'h0) hold <= hold - 2'h1;
            else if (core_request && wait_cnt == lat) begin
                core_ack <= 1'h1;
                core_ack_source <= core_source;
                wait_cnt <= 4'h0;
            end else if (core_request) wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // irqpe_core_model
`default_nettype wire

// ### tb/irqpe_tb_top.sv
// Self-checking bench for the pending and priority block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module irqpe_tb_top;
    import irqpe_pkg::*;
    logic sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_out, global_enable;
    logic low_voltage_detector, comparator_pulse, core_ack, core_request;
    logic [13:0] wb_adr_i;
    logic [3:0] wb_sel_i, port_c_pin_pulse, port_c_level_high, port_c_level_low, lat;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] port_a_pin_pulse, group0_pending_requests, port_a_level_high;
    logic [7:0] port_a_level_low, group0_ack_clear, q;
    logic [4:0] core_ack_source, core_source;
    logic [1:0] core_level;
    logic [4:0] acked[$];
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    irqpe_top irqpe_top_i (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_a_pin_pulse, .low_voltage_detector,
        .comparator_pulse, .port_c_pin_pulse, .group0_pending_requests, .port_a_level_high,
        .port_a_level_low, .port_c_level_high, .port_c_level_low, .global_enable, .core_ack,
        .core_ack_source, .core_request, .core_source, .core_level, .group0_ack_clear,
        .irq_out);
    irqpe_core_model irqpe_core_model_i (.sys_clk, .rst_b, .core_request, .core_source,
        .lat, .core_ack, .core_ack_source);
    // Clock, timeout, outside group pending bits and ack log
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (core_ack === 1'h1) acked.push_back(core_ack_source);
        if (group0_ack_clear !== 8'h00) group0_pending_requests <= 8'h00;
        if (cycles == 5000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= {24'h00_0000, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic chk_rd(input logic [11:0] idx, input logic [7:0] e);
        wb(1'h0, idx, 8'h00);
        `CHK(q, e)
    endtask
    task automatic pulse(input logic [7:0] pa, input logic [3:0] pc, input logic lv, cm);
        port_a_pin_pulse <= pa;
        port_c_pin_pulse <= pc;
        low_voltage_detector <= lv;
        comparator_pulse <= cm;
        @(posedge sys_clk);
        {port_a_pin_pulse, port_c_pin_pulse, low_voltage_detector, comparator_pulse} <= '0;
        @(posedge sys_clk);
    endtask
    task automatic t_reset;
        logic [11:0] regs [7] = '{IDX_G0_PRIO_HIGH, IDX_G0_PRIO_LOW, IDX_PORT_A_PEND,
            IDX_PORT_C_PEND, IDX_IRQ_STATUS, IDX_IRQ_MASK, 12'h0fe0};
        foreach (regs[i]) chk_rd(regs[i], 8'h00);
    endtask
    task automatic t_enables;
        wb(1'h1, IDX_G0_PRIO_HIGH, 8'hff);
        chk_rd(IDX_G0_PRIO_HIGH, 8'hff);
        wb(1'h1, IDX_G0_PRIO_LOW, 8'hff);
        chk_rd(IDX_G0_PRIO_LOW, 8'h79);
        wb(1'h1, IDX_G0_PRIO_HIGH, 8'h00);
    endtask
    task automatic t_pending;
        pulse(8'h00, 4'ha, 1'h1, 1'h1);
        chk_rd(IDX_PORT_A_PEND, 8'hc0);
        chk_rd(IDX_PORT_C_PEND, 8'h0a);
        wb(1'h1, IDX_PORT_A_PEND, 8'h00);
        pulse(8'hff, 4'h0, 1'h0, 1'h0);
        chk_rd(IDX_PORT_A_PEND, 8'hff);
        wb(1'h1, IDX_PORT_A_PEND, 8'h12);
        chk_rd(IDX_PORT_A_PEND, 8'h12);
        wb(1'h1, IDX_PORT_A_PEND, 8'h00);
        wb(1'h1, IDX_PORT_C_PEND, 8'h05);
        chk_rd(IDX_PORT_C_PEND, 8'h05);
        wb(1'h1, IDX_PORT_C_PEND, 8'h00);
        chk_rd(IDX_PORT_C_PEND, 8'h00);
    endtask
    task automatic t_forward;
        port_a_level_high <= 8'h04;
        pulse(8'h04, 4'h0, 1'h0, 1'h0);
        repeat (3) @(posedge sys_clk);
        `CHK(core_request, 1'h0)
        chk_rd(IDX_PORT_A_PEND, 8'h04);
        global_enable <= 1'h1;
        while (core_request !== 1'h1) @(posedge sys_clk);
        `CHK(core_source, 5'h0a)
        `CHK(core_level, LEVEL_2)
        repeat (6) @(posedge sys_clk);
        chk_rd(IDX_PORT_A_PEND, 8'h00);
        global_enable <= 1'h0;
        acked.delete();
    endtask
    // Three levels queued at once; the disabled one must never be taken
    task automatic t_priority;
        lat <= 4'h4;
        port_a_level_high <= 8'h08;
        port_c_level_high <= 4'h2;
        port_c_level_low <= 4'h2;
        wb(1'h1, IDX_G0_PRIO_LOW, 8'h40);
        group0_pending_requests <= 8'h40;
        pulse(8'h09, 4'h2, 1'h0, 1'h0);
        global_enable <= 1'h1;
        repeat (60) @(posedge sys_clk);
        `CHK(acked[0], 5'h11)
        `CHK(acked[1], 5'h0b)
        `CHK(acked[2], 5'h06)
        `CHK(group0_pending_requests, 8'h00)
        chk_rd(IDX_PORT_A_PEND, 8'h01);
        global_enable <= 1'h0;
    endtask
    task automatic t_irq;
        wb(1'h1, IDX_IRQ_STATUS, 8'h07);
        pulse(8'h10, 4'h0, 1'h0, 1'h0);
        chk_rd(IDX_IRQ_STATUS, 8'h01);
        `CHK(irq_out, 1'h0)
        wb(1'h1, IDX_IRQ_MASK, 8'h01);
        `CHK(irq_out, 1'h1)
        wb(1'h1, IDX_IRQ_STATUS, 8'h01);
        `CHK(irq_out, 1'h0)
    endtask
    // Inputs at time zero, reset for twenty cycles, then the scenarios
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, global_enable} = '0;
        {port_a_pin_pulse, port_c_pin_pulse, low_voltage_detector, comparator_pulse} = '0;
        {group0_pending_requests, port_a_level_high, port_a_level_low} = '0;
        {port_c_level_high, port_c_level_low, lat} = '0;
        wb_sel_i = 4'hf;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'h1;
        @(posedge sys_clk);
        t_reset;
        t_enables;
        t_pending;
        t_forward;
        t_priority;
        t_irq;
        tally_and_finish;
    end
endmodule // irqpe_tb_top
bind irqpe_top irqpe_assertions irqpe_assertions_i (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .port_a_level_high, .port_a_level_low, .global_enable, .core_ack,
    .core_ack_source, .core_request, .core_source, .core_level, .group0_ack_clear);
`default_nettype wire
